// ===== logic/oct_defs.vh
// constants for the output contact test override block
// assumes byte addresses on a 32-bit avalon-mm slave port
// Function
// - whole output group can be disabled
// - timed disable ends when timer expires
// - permanent disable holds until withdrawn
// - zone interlock and supervision never disabled
// - disable needs unlatched, no hold, control, command
// - timed force ends when timer expires
// - permanent force holds until withdrawn
// - single and group force; group wins
// - disabled contact ignores any force
// - force needs not disabled plus command
// - manual trip command driven out
`ifndef OCT_DEFS_VH
`define OCT_DEFS_VH

// register byte offsets
`define OCT_CTRL_OFF 8'h00
`define OCT_DIS_APPLY_OFF 8'h04
`define OCT_DIS_WITHDRAW_OFF 8'h08
`define OCT_DIS_PERM_OFF 8'h0c
`define OCT_DIS_TIME_OFF 8'h10
`define OCT_FSGL_APPLY_OFF 8'h14
`define OCT_FGRP_APPLY_OFF 8'h18
`define OCT_FSGL_WITHDRAW_OFF 8'h1c
`define OCT_FGRP_WITHDRAW_OFF 8'h20
`define OCT_FORCE_PERM_OFF 8'h24
`define OCT_FORCE_TIME_OFF 8'h28
`define OCT_FSGL_POS_OFF 8'h2c
`define OCT_FGRP_POS_OFF 8'h30
`define OCT_STATUS_OFF 8'h34
`define OCT_DISARMED_OFF 8'h38

// control register fields
`define OCT_CTRL_DIS_EN_BIT 0
`define OCT_CTRL_TRIP_BIT 1

// reset values and unmapped read value
`define OCT_CTRL_RST 32'h0000_0000
`define OCT_TIME_RST 32'h0000_0001
`define OCT_UNMAPPED_RD 32'h0000_0000

`endif

// ===== logic/oct_timer.v
// one override timer: permanent or timed hold of an active flag
// assumes start and stop are one-cycle pulses on clk
`timescale 1ns/1ns
module oct_timer #(
    parameter CW = 32
) (
    input wire clk, // system clock
    input wire rst, // synchronous reset, active high
    input wire start, // apply command pulse
    input wire stop, // withdraw pulse
    input wire perm, // 1 permanent, 0 timed
    input wire [CW-1:0] dur, // duration in clock ticks
    output wire active // override in effect
);
    reg active_reg;
    reg active_next;
    reg perm_reg;
    reg perm_next;
    reg [CW-1:0] cnt_reg;
    reg [CW-1:0] cnt_next;

    assign active = active_reg;

    always @* begin
        active_next = active_reg;
        perm_next = perm_reg;
        cnt_next = cnt_reg;
        if (start) begin
            // start beats a stop in the same cycle
            active_next = 1'b1;
            perm_next = perm;
            cnt_next = (dur == {CW{1'b0}}) ? {{(CW-1){1'b0}}, 1'b1} : dur;
        end else if (stop) begin
            active_next = 1'b0;
        end else if (active_reg && !perm_reg) begin
            cnt_next = cnt_reg - {{(CW-1){1'b0}}, 1'b1};
            if (cnt_reg == {{(CW-1){1'b0}}, 1'b1})
                active_next = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            active_reg <= 1'b0;
            perm_reg <= 1'b0;
            cnt_reg <= {CW{1'b0}};
        end else begin
            active_reg <= active_next;
            perm_reg <= perm_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule

// ===== logic/oct_override.v
// test override between protection logic and relay output contacts
// assumes an avalon-mm master on clk and protection inputs synchronous to clk
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
`include "oct_defs.vh"
module oct_override #(
    parameter GROUP_W = 8,
    parameter NUM_GROUPS = 2,
    parameter CW = 32,
    parameter [GROUP_W*NUM_GROUPS-1:0] EXEMPT_MASK = 16'h0000
) (
    input wire clk, // system clock
    input wire rst, // synchronous reset, active high
    input wire [7:0] avs_address, // byte address
    input wire avs_read, // read request
    input wire avs_write, // write request
    input wire [31:0] avs_writedata, // write data
    output wire [31:0] avs_readdata, // read data
    output wire avs_waitrequest, // stall, high until answer
    input wire [GROUP_W*NUM_GROUPS-1:0] prot_cmd, // protection drive per contact
    input wire [GROUP_W*NUM_GROUPS-1:0] out_latched, // contact latched
    input wire [GROUP_W*NUM_GROUPS-1:0] out_hold_running, // off-delay running
    input wire prot_trip, // protection trip command
    input wire zone_il_in, // zone interlock from protection
    input wire superv_in, // supervision contact drive
    output wire [GROUP_W*NUM_GROUPS-1:0] contact_drive, // relay contact coils
    output wire zone_il_out, // zone interlock output
    output wire superv_out, // supervision contact
    output wire trip_cmd_out // trip command to breaker
);
    localparam N_OUT = GROUP_W * NUM_GROUPS;

    // bus decode helper, used for the apply and withdraw command pulses
    function hit;
        input [7:0] addr;
        input [7:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    // bus handshake
    reg waitrequest_reg;
    reg [31:0] readdata_reg;
    reg [31:0] readdata_next;
    wire req = avs_read | avs_write;
    wire wr_go = avs_write & ~waitrequest_reg;

    // software registers
    reg [31:0] ctrl_reg;
    reg [NUM_GROUPS-1:0] dis_perm_reg;
    reg [CW-1:0] dis_time_reg;
    reg [1:0] force_perm_reg;
    reg [CW-1:0] force_time_reg;
    reg [N_OUT-1:0] fsgl_pos_reg;
    reg [NUM_GROUPS-1:0] fgrp_pos_reg;

    // command pulses into the timers
    wire [NUM_GROUPS-1:0] dis_start;
    wire [NUM_GROUPS-1:0] dis_stop;
    wire [NUM_GROUPS-1:0] fgrp_start;
    wire [NUM_GROUPS-1:0] fgrp_stop;
    wire [N_OUT-1:0] fsgl_start;
    wire [N_OUT-1:0] fsgl_stop;

    // timer states
    wire [NUM_GROUPS-1:0] dis_active;
    wire [NUM_GROUPS-1:0] fgrp_active;
    wire [N_OUT-1:0] fsgl_active;

    // contact state
    reg [N_OUT-1:0] disarmed_reg;
    reg [N_OUT-1:0] disarmed_next;
    reg [N_OUT-1:0] drive_reg;
    reg [N_OUT-1:0] drive_next;
    reg zone_il_reg;
    reg superv_reg;
    reg trip_reg;

    assign avs_waitrequest = waitrequest_reg;
    assign avs_readdata = readdata_reg;
    assign contact_drive = drive_reg;
    assign zone_il_out = zone_il_reg;
    assign superv_out = superv_reg;
    assign trip_cmd_out = trip_reg;

    // write pulses, taken at the edge where waitrequest is low
    assign dis_start = (wr_go && hit(avs_address, `OCT_DIS_APPLY_OFF)) ?
        avs_writedata[NUM_GROUPS-1:0] : {NUM_GROUPS{1'b0}};
    assign dis_stop = (wr_go && hit(avs_address, `OCT_DIS_WITHDRAW_OFF)) ?
        avs_writedata[NUM_GROUPS-1:0] : {NUM_GROUPS{1'b0}};
    assign fgrp_start = (wr_go && hit(avs_address, `OCT_FGRP_APPLY_OFF)) ?
        avs_writedata[NUM_GROUPS-1:0] : {NUM_GROUPS{1'b0}};
    assign fgrp_stop = (wr_go && hit(avs_address, `OCT_FGRP_WITHDRAW_OFF)) ?
        avs_writedata[NUM_GROUPS-1:0] : {NUM_GROUPS{1'b0}};
    assign fsgl_start = (wr_go && hit(avs_address, `OCT_FSGL_APPLY_OFF)) ?
        avs_writedata[N_OUT-1:0] : {N_OUT{1'b0}};
    assign fsgl_stop = (wr_go && hit(avs_address, `OCT_FSGL_WITHDRAW_OFF)) ?
        avs_writedata[N_OUT-1:0] : {N_OUT{1'b0}};

    // one disable timer and one group force timer per output group
    genvar g;
    generate
        for (g = 0; g < NUM_GROUPS; g = g + 1) begin : grp
            oct_timer #(.CW(CW)) dis_tmr (
                .clk(clk),
                .rst(rst),
                .start(dis_start[g]),
                .stop(dis_stop[g]),
                .perm(dis_perm_reg[g]),
                .dur(dis_time_reg),
                .active(dis_active[g])
            );
            oct_timer #(.CW(CW)) fgrp_tmr (
                .clk(clk),
                .rst(rst),
                .start(fgrp_start[g]),
                .stop(fgrp_stop[g]),
                .perm(force_perm_reg[1]),
                .dur(force_time_reg),
                .active(fgrp_active[g])
            );
        end
    endgenerate

    // one single force timer per contact
    genvar k;
    generate
        for (k = 0; k < N_OUT; k = k + 1) begin : sgl
            oct_timer #(.CW(CW)) fsgl_tmr (
                .clk(clk),
                .rst(rst),
                .start(fsgl_start[k]),
                .stop(fsgl_stop[k]),
                .perm(force_perm_reg[0]),
                .dur(force_time_reg),
                .active(fsgl_active[k])
            );
        end
    endgenerate

    // per contact disable and force resolution
    integer i;
    always @* begin
        disarmed_next = disarmed_reg;
        drive_next = drive_reg;
        for (i = 0; i < N_OUT; i = i + 1) begin
            // a contact already disabled stays so while its group is disabled and the control enable bit is set
            if (!dis_active[i / GROUP_W] || !ctrl_reg[`OCT_CTRL_DIS_EN_BIT] ||
                EXEMPT_MASK[i]) begin
                disarmed_next[i] = 1'b0;
            end else if (!out_latched[i] && !out_hold_running[i]) begin
                disarmed_next[i] = 1'b1;
            end
            if (disarmed_next[i]) begin
                drive_next[i] = drive_reg[i];
            end else if (fgrp_active[i / GROUP_W]) begin
                drive_next[i] = fgrp_pos_reg[i / GROUP_W];
            end else if (fsgl_active[i]) begin
                drive_next[i] = fsgl_pos_reg[i];
            end else begin
                drive_next[i] = prot_cmd[i];
            end
        end
    end

    // read mux
    always @* begin
        readdata_next = `OCT_UNMAPPED_RD;
        case (avs_address)
            `OCT_CTRL_OFF: readdata_next = ctrl_reg;
            `OCT_DIS_APPLY_OFF: readdata_next[NUM_GROUPS-1:0] = dis_active;
            `OCT_DIS_PERM_OFF: readdata_next[NUM_GROUPS-1:0] = dis_perm_reg;
            `OCT_DIS_TIME_OFF: readdata_next[CW-1:0] = dis_time_reg;
            `OCT_FSGL_APPLY_OFF: readdata_next[N_OUT-1:0] = fsgl_active;
            `OCT_FGRP_APPLY_OFF: readdata_next[NUM_GROUPS-1:0] = fgrp_active;
            `OCT_FORCE_PERM_OFF: readdata_next[1:0] = force_perm_reg;
            `OCT_FORCE_TIME_OFF: readdata_next[CW-1:0] = force_time_reg;
            `OCT_FSGL_POS_OFF: readdata_next[N_OUT-1:0] = fsgl_pos_reg;
            `OCT_FGRP_POS_OFF: readdata_next[NUM_GROUPS-1:0] = fgrp_pos_reg;
            `OCT_STATUS_OFF: readdata_next[N_OUT-1:0] = drive_reg;
            `OCT_DISARMED_OFF: readdata_next[N_OUT-1:0] = disarmed_reg;
            default: readdata_next = `OCT_UNMAPPED_RD;
        endcase
    end

    // bus slave: one wait cycle, then waitrequest low for one cycle
    always @(posedge clk) begin
        if (rst) begin
            waitrequest_reg <= 1'b1;
            readdata_reg <= 32'h0000_0000;
        end else begin
            if (req && waitrequest_reg) begin
                waitrequest_reg <= 1'b0;
                readdata_reg <= readdata_next;
            end else begin
                waitrequest_reg <= 1'b1;
            end
        end
    end

    // plain read/write registers
    always @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= `OCT_CTRL_RST;
            dis_perm_reg <= {NUM_GROUPS{1'b0}};
            dis_time_reg <= `OCT_TIME_RST;
            force_perm_reg <= 2'h0;
            force_time_reg <= `OCT_TIME_RST;
            fsgl_pos_reg <= {N_OUT{1'b0}};
            fgrp_pos_reg <= {NUM_GROUPS{1'b0}};
        end else if (wr_go) begin
            case (avs_address)
                `OCT_CTRL_OFF: ctrl_reg <= {30'h0000_0000, avs_writedata[1:0]};
                `OCT_DIS_PERM_OFF: dis_perm_reg <= avs_writedata[NUM_GROUPS-1:0];
                `OCT_DIS_TIME_OFF: dis_time_reg <= avs_writedata[CW-1:0];
                `OCT_FORCE_PERM_OFF: force_perm_reg <= avs_writedata[1:0];
                `OCT_FORCE_TIME_OFF: force_time_reg <= avs_writedata[CW-1:0];
                `OCT_FSGL_POS_OFF: fsgl_pos_reg <= avs_writedata[N_OUT-1:0];
                `OCT_FGRP_POS_OFF: fgrp_pos_reg <= avs_writedata[NUM_GROUPS-1:0];
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    // contact outputs
    always @(posedge clk) begin
        if (rst) begin
            disarmed_reg <= {N_OUT{1'b0}};
            drive_reg <= {N_OUT{1'b0}};
            zone_il_reg <= 1'b0;
            superv_reg <= 1'b0;
            trip_reg <= 1'b0;
        end else begin
            disarmed_reg <= disarmed_next;
            drive_reg <= drive_next;
            zone_il_reg <= zone_il_in;
            superv_reg <= superv_in;
            trip_reg <= prot_trip | ctrl_reg[`OCT_CTRL_TRIP_BIT];
        end
    end
endmodule

// ===== verif/oct_override_sva.sv
// port assertions for the output contact override block
// assumes binding into oct_override with its default widths
`timescale 1ns/1ns
module oct_override_sva #(
    parameter GROUP_W = 8,
    parameter NUM_GROUPS = 2
) (
    input wire clk, // system clock
    input wire rst, // sync reset
    input wire [7:0] avs_address, // byte address
    input wire avs_read, avs_write, // bus strobes
    input wire [31:0] avs_writedata, avs_readdata, // bus data
    input wire avs_waitrequest, // bus stall
    input wire [GROUP_W*NUM_GROUPS-1:0] prot_cmd, contact_drive, // drives
    input wire prot_trip, zone_il_in, superv_in, // protection side
    input wire zone_il_out, superv_out, trip_cmd_out // exempt and trip
);
    reg wr_seen_reg;
    always @(posedge clk) begin
        if (rst)
            wr_seen_reg <= 1'b0;
        else if (avs_write)
            wr_seen_reg <= 1'b1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_follow;
        !wr_seen_reg && !avs_write |=> contact_drive == $past(prot_cmd);
    endproperty
    a_follow: assert property (p_follow) else $error("drive not following");
    property p_wait;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("wait cycle wrong");
    property p_idle;
        !(avs_read || avs_write) |=> avs_waitrequest;
    endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address == 8'hfc |-> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_trip_prot;
        prot_trip |=> trip_cmd_out;
    endproperty
    a_trip_prot: assert property (p_trip_prot) else $error("trip not passed");
    property p_trip_ctrl;
        avs_write && !avs_waitrequest && avs_address == 8'h00 && avs_writedata[1]
            |-> ##[1:2] trip_cmd_out;
    endproperty
    a_trip_ctrl: assert property (p_trip_ctrl) else $error("manual trip lost");
    property p_zone;
        1'b1 |=> zone_il_out == $past(zone_il_in);
    endproperty
    a_zone: assert property (p_zone) else $error("zone output blocked");
    property p_superv;
        $rose(superv_in) |=> superv_out;
    endproperty
    a_superv: assert property (p_superv) else $error("supervision blocked");
    c_trip: cover property ($rose(trip_cmd_out));
    c_read: cover property (avs_read && !avs_waitrequest);
    c_apply: cover property (avs_write && !avs_waitrequest && avs_address == 8'h04);
endmodule
bind oct_override oct_override_sva #(.GROUP_W(GROUP_W), .NUM_GROUPS(NUM_GROUPS))
    oct_override_sva_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .prot_cmd(prot_cmd), .contact_drive(contact_drive), .prot_trip(prot_trip),
    .zone_il_in(zone_il_in), .superv_in(superv_in), .zone_il_out(zone_il_out),
    .superv_out(superv_out), .trip_cmd_out(trip_cmd_out));

// ===== verif/oct_contacts.sv
// breaker model behind the trip output
// assumes drives registered on clk
`timescale 1ns/1ns
module oct_contacts (
    input wire clk, // system clock
    input wire rst, // sync reset
    input wire trip_cmd_out, // trip to breaker
    output reg breaker_open_reg // breaker opened
);
    always @(posedge clk) begin
        if (rst)
            breaker_open_reg <= 1'b0;
        else if (trip_cmd_out)
            breaker_open_reg <= 1'b1;
    end
endmodule

// ===== verif/tb_oct_override.sv
// self-checking bench for the output contact override
// assumes two groups of eight contacts
`timescale 1ns/1ns
`include "oct_defs.vh"
module tb_oct_override;
    logic clk, rst, avs_read, avs_write, prot_trip, zone_il_in, superv_in;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, q;
    logic [15:0] prot_cmd, out_latched, out_hold_running;
    wire [31:0] avs_readdata;
    wire [15:0] contact_drive;
    wire avs_waitrequest, zone_il_out, superv_out, trip_cmd_out, breaker_open_reg;
    int fail_count, n_compared;
    oct_override oct_override_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .prot_cmd(prot_cmd), .out_latched(out_latched), .out_hold_running(out_hold_running),
        .prot_trip(prot_trip), .zone_il_in(zone_il_in), .superv_in(superv_in),
        .contact_drive(contact_drive), .zone_il_out(zone_il_out),
        .superv_out(superv_out), .trip_cmd_out(trip_cmd_out));
    oct_contacts oct_contacts_inst (.clk(clk), .rst(rst), .trip_cmd_out(trip_cmd_out),
        .breaker_open_reg(breaker_open_reg));
    task print_verdict;
        if (fail_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk);
        // values read here are those the slave shows at this edge
        while (avs_waitrequest !== 1'b0 && n < 99) begin
            @(posedge clk);
            n++;
        end
        if (n == 99)
            fail_count++;
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(e, q);
    endtask
    task cd(input logic [15:0] e);
        @(negedge clk);
        chk({16'h0000, e}, {16'h0000, contact_drive});
        @(posedge clk);
    endtask
    task t_regs;
        rd(`OCT_CTRL_OFF, `OCT_CTRL_RST);
        rd(`OCT_DIS_TIME_OFF, `OCT_TIME_RST);
        rd(8'hfc, `OCT_UNMAPPED_RD);
        prot_cmd <= 16'ha5c3;
        @(posedge clk);
        cd(16'ha5c3);
    endtask
    task t_dis_timed;
        prot_cmd <= 16'h00ff;
        out_latched <= 16'h0001;
        out_hold_running <= 16'h0002;
        bus(1'b1, `OCT_CTRL_OFF, 32'h1);
        bus(1'b1, `OCT_DIS_TIME_OFF, 32'h5);
        bus(1'b1, `OCT_DIS_APPLY_OFF, 32'h1);
        prot_cmd <= 16'h0000;
        @(posedge clk);
        cd(16'h00fc);
        repeat (8) @(posedge clk);
        cd(16'h0000);
        out_latched <= 16'h0000;
        out_hold_running <= 16'h0000;
    endtask
    task t_perm_force;
        prot_cmd <= 16'h00ff;
        bus(1'b1, `OCT_DIS_PERM_OFF, 32'h1);
        bus(1'b1, `OCT_DIS_APPLY_OFF, 32'h1);
        bus(1'b1, `OCT_FORCE_PERM_OFF, 32'h3);
        bus(1'b1, `OCT_FSGL_POS_OFF, 32'h0100);
        bus(1'b1, `OCT_FSGL_APPLY_OFF, 32'h0101);
        prot_cmd <= 16'h0000;
        @(posedge clk);
        cd(16'h01ff);
        repeat (20) @(posedge clk);
        cd(16'h01ff);
        bus(1'b1, `OCT_FGRP_POS_OFF, 32'h0);
        bus(1'b1, `OCT_FGRP_APPLY_OFF, 32'h3);
        cd(16'h00ff);
        bus(1'b1, `OCT_DIS_WITHDRAW_OFF, 32'h1);
        @(posedge clk);
        cd(16'h0000);
        bus(1'b1, `OCT_FGRP_WITHDRAW_OFF, 32'h3);
        bus(1'b1, `OCT_FSGL_WITHDRAW_OFF, 32'hffff);
    endtask
    task t_force_timed;
        prot_cmd <= 16'h0000;
        bus(1'b1, `OCT_FORCE_PERM_OFF, 32'h0);
        bus(1'b1, `OCT_FORCE_TIME_OFF, 32'h4);
        bus(1'b1, `OCT_FSGL_POS_OFF, 32'h0200);
        bus(1'b1, `OCT_FSGL_APPLY_OFF, 32'h0200);
        cd(16'h0200);
        repeat (8) @(posedge clk);
        cd(16'h0000);
    endtask
    task t_trip;
        zone_il_in <= 1'b1;
        superv_in <= 1'b1;
        bus(1'b1, `OCT_DIS_APPLY_OFF, 32'h3);
        @(negedge clk);
        chk(32'h3, {30'h0, zone_il_out, superv_out});
        @(posedge clk);
        bus(1'b1, `OCT_CTRL_OFF, 32'h3);
        @(posedge clk);
        @(negedge clk);
        chk(32'h3, {30'h0, trip_cmd_out, breaker_open_reg});
        @(posedge clk);
        bus(1'b1, `OCT_CTRL_OFF, 32'h0);
        prot_trip <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk(32'h1, {31'h0, trip_cmd_out});
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        {avs_read, avs_write, prot_trip, zone_il_in, superv_in} = 5'h00;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        prot_cmd = 16'h0000;
        out_latched = 16'h0000;
        out_hold_running = 16'h0000;
        fail_count = 0;
        n_compared = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_dis_timed;
        t_perm_force;
        t_force_timed;
        t_trip;
        print_verdict;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        print_verdict;
    end
endmodule
